//--- design/ctr_sel_cfg.svh
/*
 * Offsets, field positions, selector codes and reset values for the
 * counter input select and acknowledge block.
 * Assumes a 9-bit register address and 16-bit register data.
 */
`ifndef CTR_SEL_CFG_SVH
`define CTR_SEL_CFG_SVH

// register offsets
`define OFS_ACK0     9'h004
`define OFS_ACK1     9'h006
`define OFS_SEL0     9'h048
`define OFS_SEL1     9'h04A
`define OFS_ACK2     9'h104
`define OFS_ACK3     9'h106
`define OFS_SEL2     9'h148
`define OFS_SEL3     9'h14A
`define OFS_STAT     9'h1F0
`define OFS_MASK     9'h1F4
`define OFS_MODE     9'h1F8

// field positions
`define SEL_HI       15
`define SEL_LO       2
`define ACK_TC_BIT   14
`define ACK_ERR_EVEN 6
`define ACK_ERR_ODD  2
`define STAT_ERR_LO  4
`define MODE_LEVEL(i) (2*(i))
`define MODE_ALT(i)   (2*(i)+1)

// gate choice codes
`define G_OWN_SRC    5'h00
`define G_OWN_GATE   5'h01
`define G_PIN_LO     5'h02
`define G_PIN_HI     5'h09
`define G_NB_SRC     5'h0A
`define G_TRIG_LO    5'h0B
`define G_TRIG_HI    5'h11
`define G_NB_OUT     5'h14
`define G_LOW_LO     5'h1E

// source choice codes
`define S_TB1        5'h00
`define S_OWN        5'h01
`define S_PIN_LO     5'h02
`define S_PIN_HI     5'h09
`define S_NB_GATE    5'h0A
`define S_TRIG_LO    5'h0B
`define S_TRIG_HI    5'h11
`define S_TB2        5'h12
`define S_NB_TC      5'h13
`define S_TB3        5'h1E
`define S_LOW        5'h1F

// reset values
`define SEL_RST      14'h0000
`define BYTE_RST     8'h00
`define RDATA_RST    16'h0000

`endif

//--- design/ctr_sel_pkg.sv
/*
 * Types shared by the counter input select block.
 * Assumes the constants of ctr_sel_cfg.svh for field placement.
 */
`default_nettype none

package ctr_sel_pkg;

	// input select word, bits 15 down to 2
	typedef struct packed {
		logic       src_inv;
		logic       out_inv;
		logic       nb_or;
		logic       gate_bank;
		logic [4:0] gate_choice;
		logic [4:0] src_choice;
	} sel_s;

	// all pins that arrive from outside the clock domain
	typedef struct packed {
		logic [6:0] trig;
		logic [7:0] shared_src;
		logic [7:0] shared_gate;
		logic [3:0] own_gate;
		logic [3:0] own_src;
	} pins_s;

	typedef logic [4:0] code_t;

endpackage : ctr_sel_pkg

`default_nettype wire

//--- design/counter_input_select.sv
/*
 * Source and gate selection, output inversion, reload bank choice and
 * terminal-count acknowledge for four counters paired 0/1 and 2/3.
 * Assumes the counting core runs on ref_clk_i and supplies its output,
 * terminal count, error, counting and reload signals on that clock;
 * timebases arrive as same-clock levels, pins from outside.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ctr_sel_cfg.svh"

module counter_input_select (
	input  wire logic                 ref_clk_i,
	input  wire logic                 rstn_i,
	input  wire logic [8:0]           addr_i,
	input  wire logic [15:0]          wdata_i,
	input  wire logic                 wr_i,
	input  wire logic                 rd_i,
	output var  logic [15:0]          rdata_o,
	input  wire ctr_sel_pkg::pins_s   pins_i,
	input  wire logic                 tb1_i,
	input  wire logic                 tb2_i,
	input  wire logic                 tb3_i,
	input  wire logic [3:0]           counter_out_i,
	input  wire logic [3:0]           tc_i,
	input  wire logic [3:0]           tc_event_i,
	input  wire logic [3:0]           tc_err_i,
	input  wire logic [3:0]           counting_i,
	input  wire logic [3:0]           reload_i,
	output var  logic [3:0]           src_o,
	output var  logic [3:0]           gate_o,
	output var  logic [3:0]           out_o,
	output var  logic [3:0]           bank_a_o,
	output var  logic [3:0]           tc_flag_o,
	output var  logic [3:0]           tc_err_flag_o,
	output var  logic                 irq_o
);

	localparam int PW = $bits(ctr_sel_pkg::pins_s);

	localparam logic [8:0] SEL_OFS [4] = '{
		`OFS_SEL0, `OFS_SEL1, `OFS_SEL2, `OFS_SEL3
	};
	localparam logic [8:0] ACK_OFS [4] = '{
		`OFS_ACK0, `OFS_ACK1, `OFS_ACK2, `OFS_ACK3
	};

	// gate multiplexer; unlisted codes and 30/31 give a low gate
	function automatic logic pick_gate(
		input ctr_sel_pkg::code_t c,
		input logic               own_s,
		input logic               own_g,
		input logic [7:0]         pin,
		input logic               nb_s,
		input logic [6:0]         trg,
		input logic               nb_o
	);
		logic r;
		r = 1'b0;
		if (c == `G_OWN_SRC) begin
			r = own_s;
		end else if (c == `G_OWN_GATE) begin
			r = own_g;
		end else if (c >= `G_PIN_LO && c <= `G_PIN_HI) begin
			r = pin[3'(c - `G_PIN_LO)];
		end else if (c == `G_NB_SRC) begin
			r = nb_s;
		end else if (c >= `G_TRIG_LO && c <= `G_TRIG_HI) begin
			r = trg[3'(c - `G_TRIG_LO)];
		end else if (c == `G_NB_OUT) begin
			r = nb_o;
		end
		return r;
	endfunction : pick_gate

	// source multiplexer; unlisted codes and 31 give a low source
	function automatic logic pick_src(
		input ctr_sel_pkg::code_t c,
		input logic               tb1,
		input logic               own_s,
		input logic [7:0]         pin,
		input logic               nb_g,
		input logic [6:0]         trg,
		input logic               tb2,
		input logic               nb_tc,
		input logic               tb3
	);
		logic r;
		r = 1'b0;
		if (c == `S_TB1) begin
			r = tb1;
		end else if (c == `S_OWN) begin
			r = own_s;
		end else if (c >= `S_PIN_LO && c <= `S_PIN_HI) begin
			r = pin[3'(c - `S_PIN_LO)];
		end else if (c == `S_NB_GATE) begin
			r = nb_g;
		end else if (c >= `S_TRIG_LO && c <= `S_TRIG_HI) begin
			r = trg[3'(c - `S_TRIG_LO)];
		end else if (c == `S_TB2) begin
			r = tb2;
		end else if (c == `S_NB_TC) begin
			r = nb_tc;
		end else if (c == `S_TB3) begin
			r = tb3;
		end
		return r;
	endfunction : pick_src

	// pin synchroniser stages and filtered pin image
	logic [PW-1:0]       sync1;
	logic [PW-1:0]       sync2;
	logic [PW-1:0]       sync3;
	logic [PW-1:0]       pin_filt;
	logic [PW-1:0]       agree;
	logic [PW-1:0]       next_pin_filt;
	ctr_sel_pkg::pins_s  pv;

	// per-counter configuration and selection state
	ctr_sel_pkg::sel_s   sel_q [4];
	ctr_sel_pkg::sel_s   next_sel [4];
	logic [3:0]          src_raw_q;
	logic [3:0]          gate_raw_q;
	logic [3:0]          alt_a_q;
	logic [3:0]          neighbour_source_raw;
	logic [3:0]          next_gate_raw;
	logic [3:0]          next_gate_eff;
	logic [3:0]          next_alt_a;
	logic [3:0]          next_bank_a;
	logic [3:0]          next_out;
	logic [3:0]          wr_sel;
	logic [3:0]          wr_ack;
	logic [3:0]          clr_tc;
	logic [3:0]          clr_err;

	// software-visible state
	logic [7:0]          stat_q;
	logic [7:0]          mask_q;
	logic [7:0]          mode_q;
	logic [7:0]          next_stat;
	logic [7:0]          next_mask;
	logic [7:0]          next_mode;
	logic [15:0]         rmux;
	logic                wr_stat;
	logic                wr_mask;
	logic                wr_mode;

	// a pin change counts only once stages two and three agree
	assign agree         = ~(sync2 ^ sync3);
	assign next_pin_filt = (sync3 & agree) | (pin_filt & ~agree);
	assign pv            = ctr_sel_pkg::pins_s'(pin_filt);

	// sync1 feeds sync2 only, so no logic sees a metastable level
	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			sync1    <= '0;
			sync2    <= '0;
			sync3    <= '0;
			pin_filt <= '0;
		end else begin
			sync1    <= pins_i;
			sync2    <= sync1;
			sync3    <= sync2;
			pin_filt <= next_pin_filt;
		end
	end

	// address decode for the shared registers
	assign wr_stat = wr_i && (addr_i == `OFS_STAT);
	assign wr_mask = wr_i && (addr_i == `OFS_MASK);
	assign wr_mode = wr_i && (addr_i == `OFS_MODE);

	// per-counter selection, neighbour is index xor 1
	for (genvar i = 0; i < 4; i++) begin : g_ctr
		localparam int NB = i ^ 1;
		localparam int EB = (i % 2 == 0) ?
			`ACK_ERR_EVEN : `ACK_ERR_ODD;
		logic gate_or;

		assign wr_sel[i] = wr_i && (addr_i == SEL_OFS[i]);
		assign wr_ack[i] = wr_i && (addr_i == ACK_OFS[i]);

		// bits 1:0 are dropped by the slice
		assign next_sel[i] = wr_sel[i] ?
			ctr_sel_pkg::sel_s'(wdata_i[`SEL_HI:`SEL_LO]) :
			sel_q[i];

		// neighbour choices are taken registered, which breaks
		// the loop when both pick each other's selection
		assign next_gate_raw[i] = pick_gate(sel_q[i].gate_choice,
			pv.own_src[i], pv.own_gate[i], pv.shared_gate,
			src_raw_q[NB], pv.trig, counter_out_i[NB]);
		assign neighbour_source_raw[i] = pick_src(sel_q[i].src_choice,
			tb1_i, pv.own_src[i], pv.shared_src, gate_raw_q[NB],
			pv.trig, tb2_i, tc_i[NB], tb3_i);

		// idle counter with OR enabled sees only the neighbour
		assign gate_or = counting_i[i] ?
			(next_gate_raw[i] | counter_out_i[NB]) :
			counter_out_i[NB];
		assign next_gate_eff[i] = sel_q[i].nb_or ?
			gate_or : next_gate_raw[i];

		// alternation toggles on each reload, fixed mode stays on A
		assign next_alt_a[i] = mode_q[`MODE_ALT(i)] ?
			(alt_a_q[i] ^ reload_i[i]) : 1'b1;
		// level gating is left to software to configure
		assign next_bank_a[i] = sel_q[i].gate_bank ?
			next_gate_eff[i] : next_alt_a[i];

		assign next_out[i] = counter_out_i[i] ^
			sel_q[i].out_inv;

		// acks decode straight off the write; zero bits do nothing
		assign clr_tc[i] = (wr_ack[i] && wdata_i[`ACK_TC_BIT]) ||
			(wr_stat && wdata_i[i]);
		assign clr_err[i] = (wr_ack[i] && wdata_i[EB]) ||
			(wr_stat && wdata_i[i + `STAT_ERR_LO]);
	end

	// set wins over a clear in the same cycle
	assign next_stat = (stat_q & ~{clr_err, clr_tc}) |
		{tc_err_i, tc_event_i};
	assign next_mask = wr_mask ? wdata_i[7:0] : mask_q;
	assign next_mode = wr_mode ? wdata_i[7:0] : mode_q;

	// read mux; write-only registers read as zero
	assign rmux = (addr_i == `OFS_STAT) ? {8'h00, stat_q} :
		(addr_i == `OFS_MASK) ? {8'h00, mask_q} :
		(addr_i == `OFS_MODE) ? {8'h00, mode_q} :
		`RDATA_RST;

	// configuration registers
	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			for (int k = 0; k < 4; k++) begin
				sel_q[k] <= `SEL_RST;
			end
			mask_q <= `BYTE_RST;
			mode_q <= `BYTE_RST;
		end else begin
			sel_q  <= next_sel;
			mask_q <= next_mask;
			mode_q <= next_mode;
		end
	end

	// selection pipeline and outputs, one flop after the muxes
	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			src_raw_q  <= '0;
			gate_raw_q <= '0;
			alt_a_q    <= '1;
			src_o      <= '0;
			gate_o     <= '0;
			out_o      <= '0;
			bank_a_o   <= '0;
		end else begin
			src_raw_q  <= neighbour_source_raw;
			gate_raw_q <= next_gate_raw;
			alt_a_q    <= next_alt_a;
			for (int k = 0; k < 4; k++) begin
				src_o[k] <= neighbour_source_raw[k] ^
					sel_q[k].src_inv;
			end
			gate_o     <= next_gate_eff;
			out_o      <= next_out;
			bank_a_o   <= next_bank_a;
		end
	end

	// status, interrupt and read data
	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			stat_q        <= `BYTE_RST;
			tc_flag_o     <= '0;
			tc_err_flag_o <= '0;
			irq_o         <= 1'b0;
			rdata_o       <= `RDATA_RST;
		end else begin
			stat_q        <= next_stat;
			tc_flag_o     <= next_stat[3:0];
			tc_err_flag_o <= next_stat[7:4];
			irq_o         <= |(next_stat & next_mask);
			rdata_o       <= rd_i ? rmux : `RDATA_RST;
		end
	end

	// checks on counter 0, whose neighbour is counter 1, and on the interrupt
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!rstn_i);

	sequence s_ack_tc0;
		wr_i && addr_i == `OFS_ACK0 && wdata_i[`ACK_TC_BIT] &&
		!tc_event_i[0];
	endsequence

	sequence s_ack_err0;
		wr_i && addr_i == `OFS_ACK0 && wdata_i[`ACK_ERR_EVEN] &&
		!tc_err_i[0];
	endsequence

	sequence s_ack_zero0;
		wr_i && addr_i == `OFS_ACK0 && wdata_i == 16'h0000 &&
		tc_event_i == 4'h0 && tc_err_i == 4'h0;
	endsequence

	chk_src_invert: assert property (
		sel_q[0].src_inv && sel_q[0].src_choice == `S_LOW
		|=> src_o[0])
		else $error("inverted low source did not read high");

	chk_out_invert: assert property (
		1'b1 |=> out_o[0] ==
		($past(counter_out_i[0]) ^ $past(sel_q[0].out_inv)))
		else $error("counter output polarity wrong");

	chk_gate_or: assert property (
		sel_q[0].nb_or && counting_i[0] && counter_out_i[1]
		|=> gate_o[0])
		else $error("neighbour output not ORed into gate");

	chk_gate_idle: assert property (
		sel_q[0].nb_or && !counting_i[0]
		|=> gate_o[0] == $past(counter_out_i[1]))
		else $error("idle gate is not the neighbour output");

	chk_bank_gate: assert property (
		sel_q[0].gate_bank |=> bank_a_o[0] == gate_o[0])
		else $error("gate level did not pick reload bank");

	chk_gate_low: assert property (
		!sel_q[0].nb_or && sel_q[0].gate_choice >= `G_LOW_LO
		|=> !gate_o[0])
		else $error("low gate code gave a high gate");

	chk_gate_pin: assert property (
		!sel_q[0].nb_or && sel_q[0].gate_choice == `G_PIN_LO
		|=> gate_o[0] == $past(pv.shared_gate[0]))
		else $error("gate code 2 did not follow shared pin 0");

	chk_bank_fixed: assert property (
		!sel_q[0].gate_bank && !mode_q[`MODE_ALT(0)]
		|=> bank_a_o[0])
		else $error("fixed reload did not stay on bank A");

	chk_tc_clear: assert property (
		s_ack_tc0 |=> !stat_q[0] && !tc_flag_o[0])
		else $error("ack did not clear terminal-count flag");

	chk_err_clear: assert property (
		s_ack_err0 |=> !stat_q[4] && !tc_err_flag_o[0])
		else $error("ack did not clear terminal-count error");

	chk_ack_zero: assert property (
		s_ack_zero0 |=> stat_q == $past(stat_q))
		else $error("writing zero to ack changed status");

	chk_sel_update: assert property (
		wr_sel[0] |=> sel_q[0] ==
		$past(wdata_i[`SEL_HI:`SEL_LO]))
		else $error("select register did not take the write");

	chk_irq_level: assert property (
		irq_o == |(stat_q & mask_q))
		else $error("interrupt out of step with status");

endmodule : counter_input_select

`default_nettype wire

//--- tb/tb.sv
/*
 * Self-checking bench for counter_input_select: selectors, inversion,
 * neighbour gate, reload bank choice, flags, acknowledge and interrupt.
 * Assumes the bench stands in for the counting core, the pins and the
 * register bus master, all on the one 25 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ctr_sel_cfg.svh"

module tb;

	logic                ref_clk_i, rstn_i, wr_i, rd_i, irq_o;
	logic                tb1_i, tb2_i, tb3_i;
	logic [8:0]          addr_i;
	logic [15:0]         wdata_i, rdata_o;
	ctr_sel_pkg::pins_s  pins_i;
	logic [3:0]          counter_out_i, tc_i, tc_event_i, tc_err_i;
	logic [3:0]          counting_i, reload_i, src_o, gate_o, out_o;
	logic [3:0]          bank_a_o, tc_flag_o, tc_err_flag_o;
	int                  n_errors, total_checks;
	logic                e;

	counter_input_select counter_input_select_inst (.ref_clk_i, .rstn_i,
		.addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .pins_i, .tb1_i, .tb2_i,
		.tb3_i, .counter_out_i, .tc_i, .tc_event_i, .tc_err_i, .counting_i,
		.reload_i, .src_o, .gate_o, .out_o, .bank_a_o, .tc_flag_o,
		.tc_err_flag_o, .irq_o);

	// free-running 25 MHz clock
	initial begin
		ref_clk_i = 1'b0;
		forever #20 ref_clk_i = ~ref_clk_i;
	end

	task chk(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	// sample a little after the edge so its updates have landed
	task cyc(input int n);
		repeat (n) @(posedge ref_clk_i);
		#1;
	endtask : cyc

	task wreg(input logic [8:0] a, input logic [15:0] d);
		@(posedge ref_clk_i);
		addr_i  <= a;
		wdata_i <= d;
		wr_i    <= 1'b1;
		@(posedge ref_clk_i);
		wr_i    <= 1'b0;
	endtask : wreg

	// read data stand only in the cycle after the strobe
	task rreg(input logic [8:0] a, input logic [15:0] exp);
		@(posedge ref_clk_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge ref_clk_i);
		rd_i   <= 1'b0;
		#1;
		chk(rdata_o, exp);
	endtask : rreg

	function automatic logic [15:0] sw(input logic si, oi, nb, bk,
		input logic [4:0] g, s);
		return {si, oi, nb, bk, g, s, 2'h0};
	endfunction : sw

	// light only the line a code picks; dead codes see every line high
	task light(input bit gate, input int c, output logic x);
		ctr_sel_pkg::pins_s p;
		logic [2:0]         t;
		logic [3:0]         co, tc;
		bit                 dead;
		p = '0;
		t = '0;
		co = '0;
		tc = '0;
		x = 1'b1;
		dead = 1'b0;
		if (gate) begin
			case (c) inside
				0:       p.own_src[0] = 1'b1;
				1:       p.own_gate[0] = 1'b1;
				[2:9]:   p.shared_gate[c-2] = 1'b1;
				10:      t[2] = 1'b1;
				[11:17]: p.trig[c-11] = 1'b1;
				20:      co[1] = 1'b1;
				default: dead = 1'b1;
			endcase
		end else begin
			case (c) inside
				0:       t[2] = 1'b1;
				1:       p.own_src[0] = 1'b1;
				[2:9]:   p.shared_src[c-2] = 1'b1;
				10:      p.own_src[1] = 1'b1;
				[11:17]: p.trig[c-11] = 1'b1;
				18:      t[1] = 1'b1;
				19:      tc[1] = 1'b1;
				30:      t[0] = 1'b1;
				default: dead = 1'b1;
			endcase
		end
		// dead codes see every line high, so a stray pick shows up
		if (dead) begin
			p = '1;
			t = '1;
			co = '1;
			tc = '1;
			x = 1'b0;
		end
		@(posedge ref_clk_i);
		pins_i <= p;
		{tb1_i, tb2_i, tb3_i} <= t;
		counter_out_i <= co;
		tc_i <= tc;
	endtask : light

	// every source code, plain and inverted; neighbour paths lag a cycle
	task t_src();
		for (int c = 0; c < 32; c++) begin
			for (int inv = 0; inv < 2; inv++) begin
				light(1'b0, c, e);
				wreg(`OFS_SEL0, sw(inv[0], 1'b0, 1'b0, 1'b0, 5'h00, c[4:0]));
				cyc(8);
				chk(src_o[0], e ^ inv[0]);
			end
		end
		$display("test source select done");
	endtask : t_src

	task t_gate();
		for (int c = 0; c < 32; c++) begin
			light(1'b1, c, e);
			wreg(`OFS_SEL0, sw(1'b0, 1'b0, 1'b0, 1'b0, c[4:0], 5'h1F));
			cyc(8);
			chk(gate_o[0], e);
		end
		$display("test gate select done");
	endtask : t_gate

	task t_out();
		@(posedge ref_clk_i);
		counter_out_i <= 4'h5;
		wreg(`OFS_SEL0, 16'h4001);
		cyc(3);
		chk(out_o, 4'h4);
		wreg(`OFS_SEL0, 16'h0000);
		cyc(3);
		chk(out_o, 4'h5);
		$display("test output invert done");
	endtask : t_out

	// rows: or-bit, gate code, own gate, counting, neighbour out, expected
	task t_or();
		logic [9:0]         rows [6];
		ctr_sel_pkg::pins_s p;
		rows = '{10'h3D3, 10'h218, 10'h21D, 10'h3C7, 10'h1E6, 10'h01B};
		for (int k = 0; k < 6; k++) begin
			p = '0;
			p.own_gate[0] = rows[k][3];
			@(posedge ref_clk_i);
			pins_i <= p;
			counting_i <= {3'h0, rows[k][2]};
			counter_out_i <= {2'h0, rows[k][1], 1'b0};
			wreg(`OFS_SEL0, sw(1'b0, 1'b0, rows[k][9], 1'b0, rows[k][8:4], 5'h00));
			cyc(8);
			chk(gate_o[0], rows[k][0]);
		end
		$display("test neighbour gate done");
	endtask : t_or

	task rl();
		@(posedge ref_clk_i);
		reload_i <= 4'h1;
		@(posedge ref_clk_i);
		reload_i <= 4'h0;
		cyc(2);
	endtask : rl

	task t_bank();
		ctr_sel_pkg::pins_s p;
		wreg(`OFS_MODE, 16'h0001);
		for (int g = 1; g >= 0; g--) begin
			p = '0;
			p.own_gate[0] = g[0];
			@(posedge ref_clk_i);
			pins_i <= p;
			wreg(`OFS_SEL0, sw(1'b0, 1'b0, 1'b0, 1'b1, 5'h01, 5'h00));
			cyc(8);
			chk(bank_a_o[0], g[0]);
		end
		wreg(`OFS_SEL0, 16'h0000);
		wreg(`OFS_MODE, 16'h0002);
		cyc(2);
		chk(bank_a_o[0], 1'b1);
		rl();
		chk(bank_a_o[0], 1'b0);
		rl();
		chk(bank_a_o[0], 1'b1);
		wreg(`OFS_MODE, 16'h0000);
		rl();
		chk(bank_a_o[0], 1'b1);
		$display("test reload bank done");
	endtask : t_bank

	task t_irq();
		logic [8:0] ack [4];
		ack = '{`OFS_ACK0, `OFS_ACK1, `OFS_ACK2, `OFS_ACK3};
		wreg(`OFS_MASK, 16'h00FF);
		for (int i = 0; i < 4; i++) begin
			@(posedge ref_clk_i);
			tc_event_i <= 4'h1 << i;
			tc_err_i <= 4'h1 << i;
			@(posedge ref_clk_i);
			tc_event_i <= 4'h0;
			tc_err_i <= 4'h0;
			cyc(1);
			chk({tc_err_flag_o, tc_flag_o, irq_o}, (9'h22 << i) | 9'h1);
			wreg(ack[i], 16'h0000);
			wreg(ack[i], i[0] ? 16'h0040 : 16'h0004);
			cyc(2);
			chk({tc_err_flag_o, tc_flag_o}, 8'h11 << i);
			wreg(ack[i], 16'h4000);
			cyc(1);
			chk({tc_err_flag_o, tc_flag_o, irq_o}, (9'h20 << i) | 9'h1);
			wreg(ack[i], i[0] ? 16'h0004 : 16'h0040);
			cyc(1);
			chk({tc_err_flag_o, tc_flag_o, irq_o}, 9'h000);
		end
		// an acknowledge leaves nothing behind to eat the next event
		@(posedge ref_clk_i);
		tc_event_i <= 4'h1;
		@(posedge ref_clk_i);
		tc_event_i <= 4'h0;
		cyc(4);
		chk({tc_flag_o, irq_o}, 5'h03);
		wreg(`OFS_MASK, 16'h0010);
		cyc(1);
		chk(irq_o, 1'b0);
		wreg(9'h010, 16'hFFFF);
		rreg(`OFS_MASK, 16'h0010);
		rreg(`OFS_STAT, 16'h0001);
		rreg(`OFS_SEL0, 16'h0000);
		rreg(9'h010, 16'h0000);
		wreg(`OFS_STAT, 16'h0001);
		rreg(`OFS_STAT, 16'h0000);
		$display("test flags and interrupt done");
	endtask : t_irq

	task finish_test();
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : finish_test

	// cut a hang short, far beyond the 1300 or so cycles the run needs
	initial begin
		#1000000;
		n_errors++;
		finish_test();
	end

	initial begin
		rstn_i = 1'b0;
		wr_i = 1'b0;
		rd_i = 1'b0;
		addr_i = 9'h000;
		wdata_i = 16'h0000;
		pins_i = '0;
		{tb1_i, tb2_i, tb3_i} = 3'h0;
		{counter_out_i, tc_i, tc_event_i, tc_err_i} = 16'h0000;
		{counting_i, reload_i} = 8'h00;
		// three edges in reset, release launched at the third
		repeat (3) @(posedge ref_clk_i);
		rstn_i <= 1'b1;
		#1;
		chk({src_o, gate_o, out_o, bank_a_o}, 16'h0000);
		chk({tc_flag_o, tc_err_flag_o, irq_o}, 9'h000);
		t_src();
		t_gate();
		t_out();
		t_or();
		t_bank();
		t_irq();
		finish_test();
	end

endmodule : tb

`default_nettype wire
